// ==== inc/strobe_dec_pkg.sv ====
/*
 * Package for the port chip-select decoder: register offsets, field layout,
 * reset values, encodings and the carrier structs shared by the design.
 * Assumes an 8-bit register port with byte offsets as printed for the core.
 */
package strobe_dec_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_LOW = 8'hc2;   // Pins 0 and 1 configuration.
    localparam logic [7:0] OFS_CFG_HIGH = 8'hc3;  // Pins 2 and 3 configuration.
    localparam logic [7:0] OFS_POLARITY = 8'hae;  // Strobe polarity bits 7..4.
    localparam logic [7:0] OFS_BASE_L0 = 8'h84;   // Base address low, pin 0.
    localparam logic [7:0] OFS_BASE_H0 = 8'h85;   // Base address high, pin 0.
    localparam logic [7:0] OFS_BASE_L1 = 8'h94;
    localparam logic [7:0] OFS_BASE_H1 = 8'h95;
    localparam logic [7:0] OFS_BASE_L2 = 8'hac;
    localparam logic [7:0] OFS_BASE_H2 = 8'had;
    localparam logic [7:0] OFS_BASE_L3 = 8'hb4;
    localparam logic [7:0] OFS_BASE_H3 = 8'hb5;
    localparam logic [7:0] OFS_PORT_DATA = 8'hd8; // Port data latch.

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int FUN_POS_ODD = 6;   // Function field of the odd pin.
    localparam int CMP_POS_ODD = 4;   // Compare-length field of the odd pin.
    localparam int FUN_POS_EVEN = 2;  // Function field of the even pin.
    localparam int CMP_POS_EVEN = 0;  // Compare-length field of the even pin.
    localparam int POL_POS = 4;       // Polarity bit of pin 0 in its register.
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [3:0] RST_POL = 4'h0;
    localparam logic [15:0] RST_BASE = 16'h0000;
    localparam logic [3:0] RST_PORT = 4'hf;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] FUN_IO = 2'h0;
    localparam logic [1:0] FUN_RD = 2'h1;
    localparam logic [1:0] FUN_WR = 2'h2;
    localparam logic [1:0] FUN_RW = 2'h3;
    localparam logic [1:0] CMP_FULL = 2'h0;
    localparam logic [1:0] CMP_A15_1 = 2'h1;
    localparam logic [1:0] CMP_A15_2 = 2'h2;
    localparam logic [1:0] CMP_A15_8 = 2'h3;

    // ------------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
    } xbus_t;

    typedef struct packed {
        logic [7:0] cfg_low;
        logic [7:0] cfg_high;
        logic [3:0] polarity;
        logic [3:0][15:0] base;
        logic [3:0] port;
        logic [7:0] rdata;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
    } state_t;
endpackage

// ==== rtl/port_chip_select_decoder.sv ====
/*
 * Port chip-select decoder: four low port pins serve either as plain
 * quasi-bidirectional I/O bits or as address-matched chip-select strobes.
 * Software sets each pin up through two configuration bytes, a polarity
 * byte and a pair of base-address bytes per pin. The external bus is
 * decoded every cycle and the result is registered onto the pins, so a
 * strobe follows the bus one clock later. The port data latch drives
 * the pins that are left in I/O mode.
 *
 * Assumes the external bus address and read/write strobes are synchronous
 * to clk, and that the register master follows the one-cycle strobe port.
 * Assumes the pads carry a pull-up, so a released I/O pin reads as one.
 * Assumes the bus never raises read and write together; if it does, a
 * read/write strobe pin simply fires once for both.
 */
`timescale 1ns/1ps
module port_chip_select_decoder (
    clk,
    rst,
    req,
    rdata,
    xbus,
    pin_in,
    pin_out,
    pin_oe_n
);
    input wire logic clk;                       // Core clock, 200 MHz.
    input wire logic rst;                       // Synchronous reset, active high.
    input wire strobe_dec_pkg::reg_req_t req;   // Register port request.
    output logic [7:0] rdata;                   // Read data, one cycle after read.
    input wire strobe_dec_pkg::xbus_t xbus;     // External bus address and strobes.
    input wire logic [3:0] pin_in;              // Pin levels as seen at the pads.
    output logic [3:0] pin_out;                 // Pin drive value.
    output logic [3:0] pin_oe_n;                // Low while the pin is driven.

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Compares an address against a base with the low bits masked by length.
    // A one in the mask marks a compared bit; the masked-off low bits are
    // don't-cares, which is what turns one base into an aligned window.
    function automatic logic addr_match(input logic [15:0] a, input logic [15:0] b,
                                        input logic [1:0] len);
        logic [15:0] mask;
        mask = 16'hffff;
        case (len)
            strobe_dec_pkg::CMP_FULL: mask = 16'hffff;
            strobe_dec_pkg::CMP_A15_1: mask = 16'hfffe;
            strobe_dec_pkg::CMP_A15_2: mask = 16'hfffc;
            strobe_dec_pkg::CMP_A15_8: mask = 16'hff00;
            default: mask = 16'hffff;
        endcase
        return ((a ^ b) & mask) == 16'h0000;
    endfunction

    // Returns the function field of pin n from the two config registers.
    // Each byte carries two pins: the even pin sits in the low nibble.
    function automatic logic [1:0] pin_fun(input logic [7:0] lo, input logic [7:0] hi,
                                           input int n);
        logic [1:0] f;
        case (n)
            0: f = lo[strobe_dec_pkg::FUN_POS_EVEN +: 2];
            1: f = lo[strobe_dec_pkg::FUN_POS_ODD +: 2];
            2: f = hi[strobe_dec_pkg::FUN_POS_EVEN +: 2];
            default: f = hi[strobe_dec_pkg::FUN_POS_ODD +: 2];
        endcase
        return f;
    endfunction

    // Returns the compare-length field of pin n.
    // The compare pair sits below the function pair in each nibble.
    function automatic logic [1:0] pin_cmp(input logic [7:0] lo, input logic [7:0] hi,
                                           input int n);
        logic [1:0] c;
        case (n)
            0: c = lo[strobe_dec_pkg::CMP_POS_EVEN +: 2];
            1: c = lo[strobe_dec_pkg::CMP_POS_ODD +: 2];
            2: c = hi[strobe_dec_pkg::CMP_POS_EVEN +: 2];
            default: c = hi[strobe_dec_pkg::CMP_POS_ODD +: 2];
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Register map, one byte per place: configuration for pins 1 and 0,
    // configuration for pins 3 and 2 (odd pin in the high nibble, with
    // the function pair above the compare-length pair), polarity in bits
    // 7..4 for pins 3..0, a base low and base high byte per pin, and the
    // port data latch in bits 3..0. Reads have no side effects, so
    // software may poll any place freely; unmapped places read as zero.
    strobe_dec_pkg::state_t s_q; // All registered state.
    strobe_dec_pkg::state_t s_d; // Next value of the state.
    logic [3:0] strobe_act;      // Per-pin strobe active, before polarity.
    logic [3:0] is_strobe;       // Per-pin: configured as a strobe.

    // ------------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------------

    // The match is purely combinational on the current bus address, so a
    // configuration write lands on the very next external cycle.
    // Limitation: the window is aligned to its own size, so base bits that
    // fall under the mask are ignored; software should keep them clear.
    // The loop index picks which pin's fields each copy decodes.
    for (genvar g = 0; g < 4; g++) begin : g_dec
        logic [1:0] fn;
        logic hit;
        assign fn = pin_fun(s_q.cfg_low, s_q.cfg_high, g);
        assign hit = addr_match(xbus.addr, s_q.base[g],
                                pin_cmp(s_q.cfg_low, s_q.cfg_high, g));
        assign is_strobe[g] = fn != strobe_dec_pkg::FUN_IO;
        // Gating with the bus strobes keeps the pin quiet outside the cycle.
        assign strobe_act[g] = hit & (
            (xbus.rd & (fn == strobe_dec_pkg::FUN_RD)) |
            (xbus.wr & (fn == strobe_dec_pkg::FUN_WR)) |
            ((xbus.rd | xbus.wr) & (fn == strobe_dec_pkg::FUN_RW)));
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Register writes, read mux and pin drive are all computed here.
    // A read in the same cycle as a write sees the value from before the
    // write; the master never does this, and it keeps the read path short.
    always_comb begin
        s_d = s_q;
        if (req.wr) begin
            case (req.addr)
                strobe_dec_pkg::OFS_CFG_LOW: s_d.cfg_low = req.wdata;
                strobe_dec_pkg::OFS_CFG_HIGH: s_d.cfg_high = req.wdata;
                strobe_dec_pkg::OFS_POLARITY: s_d.polarity = req.wdata[7:4];
                strobe_dec_pkg::OFS_BASE_L0: s_d.base[0][7:0] = req.wdata;
                strobe_dec_pkg::OFS_BASE_H0: s_d.base[0][15:8] = req.wdata;
                strobe_dec_pkg::OFS_BASE_L1: s_d.base[1][7:0] = req.wdata;
                strobe_dec_pkg::OFS_BASE_H1: s_d.base[1][15:8] = req.wdata;
                strobe_dec_pkg::OFS_BASE_L2: s_d.base[2][7:0] = req.wdata;
                strobe_dec_pkg::OFS_BASE_H2: s_d.base[2][15:8] = req.wdata;
                strobe_dec_pkg::OFS_BASE_L3: s_d.base[3][7:0] = req.wdata;
                strobe_dec_pkg::OFS_BASE_H3: s_d.base[3][15:8] = req.wdata;
                strobe_dec_pkg::OFS_PORT_DATA: s_d.port = req.wdata[3:0];
                default: s_d.port = s_q.port; // Unmapped writes are ignored.
            endcase
        end
        // Read data holds only in the cycle after the read; zero otherwise.
        // Clearing it every idle cycle means a stale byte can never be
        // mistaken for a fresh answer.
        s_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                strobe_dec_pkg::OFS_CFG_LOW: s_d.rdata = s_q.cfg_low;
                strobe_dec_pkg::OFS_CFG_HIGH: s_d.rdata = s_q.cfg_high;
                strobe_dec_pkg::OFS_POLARITY: s_d.rdata = {s_q.polarity, 4'h0};
                strobe_dec_pkg::OFS_BASE_L0: s_d.rdata = s_q.base[0][7:0];
                strobe_dec_pkg::OFS_BASE_H0: s_d.rdata = s_q.base[0][15:8];
                strobe_dec_pkg::OFS_BASE_L1: s_d.rdata = s_q.base[1][7:0];
                strobe_dec_pkg::OFS_BASE_H1: s_d.rdata = s_q.base[1][15:8];
                strobe_dec_pkg::OFS_BASE_L2: s_d.rdata = s_q.base[2][7:0];
                strobe_dec_pkg::OFS_BASE_H2: s_d.rdata = s_q.base[2][15:8];
                strobe_dec_pkg::OFS_BASE_L3: s_d.rdata = s_q.base[3][7:0];
                strobe_dec_pkg::OFS_BASE_H3: s_d.rdata = s_q.base[3][15:8];
                // Port read returns pin levels, as a quasi-bidirectional port does.
                strobe_dec_pkg::OFS_PORT_DATA: s_d.rdata = {4'h0, pin_in};
                default: s_d.rdata = 8'h00; // Unmapped reads return zero.
            endcase
        end
        // Registering the decoded strobe costs one cycle of latency, but it
        // keeps address-decode glitches off the pins.
        // Pin drive: a strobe pin is always driven; an I/O pin drives only a 0
        // and floats for a 1, so the pad can be read back like a port bit.
        for (int i = 0; i < 4; i++) begin
            if (is_strobe[i]) begin
                s_d.pin_out[i] = ~(strobe_act[i] ^ s_q.polarity[i]);
                s_d.pin_oe_n[i] = 1'b0;
            end else begin
                s_d.pin_out[i] = 1'b0;
                s_d.pin_oe_n[i] = s_q.port[i];
            end
        end
    end

    // Registers the whole state on every edge; reset loads constants only.
    // After reset every pin is an I/O pin with its latch at one, so all
    // four come out released and no peripheral is selected by accident.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.cfg_low <= strobe_dec_pkg::RST_CFG;
            s_q.cfg_high <= strobe_dec_pkg::RST_CFG;
            s_q.polarity <= strobe_dec_pkg::RST_POL;
            s_q.base <= {4{strobe_dec_pkg::RST_BASE}};
            s_q.port <= strobe_dec_pkg::RST_PORT;
            s_q.rdata <= 8'h00;
            s_q.pin_out <= 4'h0;
            s_q.pin_oe_n <= 4'hf;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign pin_out = s_q.pin_out;
    assign pin_oe_n = s_q.pin_oe_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // All checks run on the core clock and stay quiet while reset is high;
    // each one checks what this block computes or drives, taking bus master signals only as conditions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // An I/O pin never drives a one; a one is left to the pull-up.
    io_mode_pin_a: assert property (
        (pin_fun(s_q.cfg_low, s_q.cfg_high, 0) == 2'h0) |=> pin_out[0] == 1'b0)
        else $error("I/O pin 0 drove a one.");

    // An I/O pin is released exactly where its latch bit is one.
    io_release_a: assert property (
        !is_strobe[1] |=> pin_oe_n[1] == $past(s_q.port[1]))
        else $error("I/O pin 1 drive enable wrong.");

    // A strobe pin is driven at all times, active or not.
    strobe_drive_a: assert property (
        is_strobe[2] |=> !pin_oe_n[2])
        else $error("Strobe pin 2 released.");

    // A read-strobe pin rests at its inactive level while no read runs.
    rd_strobe_a: assert property (
        (pin_fun(s_q.cfg_low, s_q.cfg_high, 3) == strobe_dec_pkg::FUN_RD) && !xbus.rd
        |=> pin_out[3] == ~$past(s_q.polarity[3]))
        else $error("Read strobe active without read.");

    // A write-strobe pin stays quiet on reads.
    wr_only_a: assert property (
        (pin_fun(s_q.cfg_low, s_q.cfg_high, 1) == strobe_dec_pkg::FUN_WR) && !xbus.wr
        |-> !strobe_act[1])
        else $error("Write strobe fired without write.");

    // An active strobe shows the level that its polarity bit asks for.
    wr_strobe_a: assert property (
        is_strobe[0] && strobe_act[0] |=> pin_out[0] == $past(s_q.polarity[0]))
        else $error("Strobe pin 0 wrong level.");

    // A read/write strobe pin also answers a matching write.
    rw_both_a: assert property (
        (pin_fun(s_q.cfg_low, s_q.cfg_high, 1) == 2'h3)
        && xbus.wr && addr_match(xbus.addr, s_q.base[1], s_q.cfg_low[5:4])
        |-> strobe_act[1]) else $error("RW strobe missed write.");

    // Upper-byte compare ignores the whole low byte.
    mask_a15_8_a: assert property (
        (s_q.cfg_low[1:0] == 2'h3) && (s_q.cfg_low[3:2] == 2'h2)
        && xbus.wr && xbus.addr[15:8] == s_q.base[0][15:8] |-> strobe_act[0])
        else $error("Upper byte match missed.");

    // Full compare rejects any address but the base itself.
    full_cmp_a: assert property (
        (s_q.cfg_low[1:0] == 2'h0) && xbus.addr != s_q.base[0] |-> !strobe_act[0])
        else $error("Full compare matched wrong address.");

    // Fifteen-bit compare ignores only the lowest address bit.
    mask_a15_1_a: assert property (
        (s_q.cfg_high[1:0] == 2'h1) && (s_q.cfg_high[3:2] == 2'h1)
        && xbus.rd && xbus.addr[15:1] == s_q.base[2][15:1] |-> strobe_act[2])
        else $error("A15-A1 compare missed.");

    // A write-strobe pin stays quiet without a bus write.
    no_wr_rd_a: assert property (
        (s_q.cfg_high[3:2] == 2'h2) && !xbus.wr |-> !strobe_act[2])
        else $error("Write strobe without write.");

    // The high configuration byte reads back one cycle after the strobe.
    read_lat_a: assert property (
        req.rd && req.addr == 8'hc3 && !req.wr |=> rdata == $past(s_q.cfg_high))
        else $error("Config read wrong.");

    // A base high byte reads back one cycle after the strobe.
    base_read_a: assert property (
        req.rd && req.addr == strobe_dec_pkg::OFS_BASE_H3
        |=> rdata == $past(s_q.base[3][15:8]))
        else $error("Base high read wrong.");

    // Main scenarios that the bench is expected to reach.
    rd_hit_c: cover property (xbus.rd && |strobe_act);
    wr_hit_c: cover property (xbus.wr && |strobe_act);
    io_mode_c: cover property (!is_strobe[3] && !pin_oe_n[3]);
    low_active_c: cover property (|(strobe_act & ~s_q.polarity));
    masked_hit_c: cover property (strobe_act[0] && xbus.addr != s_q.base[0]);
endmodule

// ==== sim/strobe_peripherals.sv ====
/*
 * Far-side model: the external peripherals hanging on the four strobe pins.
 * Assumes the pins carry a weak pull-up, as a quasi-bidirectional port does,
 * and that a peripheral may hold a released pin low when the bench says so.
 */
`timescale 1ns/1ps
module strobe_peripherals (
    pin_out,
    pin_oe_n,
    hold_low,
    pad
);
    input wire logic [3:0] pin_out;   // Drive value from the decoder.
    input wire logic [3:0] pin_oe_n;  // Low while the decoder drives the pin.
    input wire logic [3:0] hold_low;  // Peripheral pulls a released pin low.
    output logic [3:0] pad;           // Resolved level seen at the pads.

    // ------------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------------
    // A released pin falls back to the pull-up, never to the last driven
    // value, so a design that floats a strobe cannot pass by luck.
    always_comb begin
        pad = (~pin_oe_n & pin_out) | (pin_oe_n & ~hold_low);
    end
endmodule

// ==== sim/testbench.sv ====
/*
 * Self-checking bench for the port chip-select decoder: a table of strobe
 * cases, then register, port-mode and reset cases written out by hand.
 * Assumes the decoder package is compiled first and the partner model is present.
 */
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------------
    // Stimulus table
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pin;   // Pin under test.
        logic [1:0] fun;   // Function field.
        logic [1:0] cmp;   // Compare-length field.
        logic pol;         // Polarity bit.
        logic [15:0] base; // Base address.
        logic [15:0] xa;   // Bus address.
        logic rd;          // Bus read strobe.
        logic wr;          // Bus write strobe.
        logic act;         // Strobe expected active.
    } row_t;
    localparam row_t rows [17] = '{
        {2'h0, 2'h2, 2'h3, 1'h1, 16'h9a00, 16'h9a55, 1'h0, 1'h1, 1'h1},
        {2'h0, 2'h1, 2'h0, 1'h1, 16'h1234, 16'h1234, 1'h1, 1'h0, 1'h1},
        {2'h0, 2'h1, 2'h0, 1'h1, 16'h1234, 16'h1234, 1'h0, 1'h1, 1'h0},
        {2'h0, 2'h1, 2'h0, 1'h0, 16'h1234, 16'h1235, 1'h1, 1'h0, 1'h0},
        {2'h1, 2'h2, 2'h1, 1'h0, 16'h1234, 16'h1235, 1'h0, 1'h1, 1'h1},
        {2'h1, 2'h2, 2'h1, 1'h1, 16'h1234, 16'h1236, 1'h0, 1'h1, 1'h0},
        {2'h1, 2'h2, 2'h1, 1'h1, 16'h1234, 16'h1234, 1'h1, 1'h0, 1'h0},
        {2'h1, 2'h3, 2'h0, 1'h1, 16'h5678, 16'h5678, 1'h0, 1'h1, 1'h1},
        {2'h2, 2'h2, 2'h2, 1'h1, 16'h1234, 16'h1237, 1'h0, 1'h1, 1'h1},
        {2'h2, 2'h3, 2'h2, 1'h0, 16'h1234, 16'h1238, 1'h1, 1'h0, 1'h0},
        {2'h2, 2'h3, 2'h3, 1'h1, 16'h1200, 16'h12ff, 1'h1, 1'h0, 1'h1},
        {2'h2, 2'h1, 2'h1, 1'h0, 16'hbeef, 16'hbeee, 1'h1, 1'h0, 1'h1},
        {2'h3, 2'h3, 2'h3, 1'h0, 16'h1200, 16'h13ff, 1'h0, 1'h1, 1'h0},
        {2'h3, 2'h3, 2'h3, 1'h1, 16'h12ab, 16'h1200, 1'h0, 1'h1, 1'h1},
        {2'h3, 2'h3, 2'h0, 1'h1, 16'h12ab, 16'h12ab, 1'h1, 1'h0, 1'h1},
        {2'h3, 2'h3, 2'h0, 1'h1, 16'h12ab, 16'h12ab, 1'h0, 1'h0, 1'h0},
        {2'h3, 2'h1, 2'h1, 1'h0, 16'h4000, 16'h4001, 1'h0, 1'h1, 1'h0}
    };
    localparam logic [7:0] base_lo_ofs [4] = '{strobe_dec_pkg::OFS_BASE_L0,
        strobe_dec_pkg::OFS_BASE_L1, strobe_dec_pkg::OFS_BASE_L2, strobe_dec_pkg::OFS_BASE_L3};

    logic clk = 1'h0;                        // Core clock.
    logic rst = 1'h1;                        // Reset, held for 20 cycles.
    strobe_dec_pkg::reg_req_t req = '0;      // Register port request.
    strobe_dec_pkg::xbus_t xbus = '0;        // External bus.
    logic [3:0] hold_low = 4'h0;             // Peripheral pull-down command.
    logic [7:0] rdata;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic [7:0] rv;
    logic [15:0] cfg;
    logic lvl;
    int err_count = 0;
    int check_count = 0;
    int cycle_count = 0;

    always #2.5 clk = ~clk;

    port_chip_select_decoder u_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .xbus(xbus), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    strobe_peripherals u_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .hold_low(hold_low), .pad(pin_in));

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    // Each bus task starts and ends on a rising edge; the idle cycle at the end
    // keeps a strobe from being assigned twice in one time step.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        req.wr <= 1'h0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        req.rd <= 1'h0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk4(input string n, input logic [3:0] e, input logic [3:0] g);
        chk8(n, {4'h0, e}, {4'h0, g});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang is cut off well past the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 4000) begin
            err_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        @(negedge clk);
        chk4("reset pin_out", 4'h0, pin_out);
        chk4("reset pin_oe_n", 4'hf, pin_oe_n);
        @(posedge clk);
        for (int p = 0; p < 4; p++) begin
            reg_rd(base_lo_ofs[p], rv);
            chk8("reset base low", 8'h00, rv);
            reg_rd(base_lo_ofs[p] + 8'h01, rv);
            chk8("reset base high", 8'h00, rv);
        end
        // Table cases: one pin is set up, the others stay plain port bits.
        foreach (rows[i]) begin
            cfg = 16'({rows[i].fun, rows[i].cmp}) << (4 * rows[i].pin);
            reg_wr(strobe_dec_pkg::OFS_CFG_LOW, cfg[7:0]);
            reg_wr(strobe_dec_pkg::OFS_CFG_HIGH, cfg[15:8]);
            reg_wr(strobe_dec_pkg::OFS_POLARITY, 8'({rows[i].pol}) << (4 + rows[i].pin));
            reg_wr(base_lo_ofs[rows[i].pin], rows[i].base[7:0]);
            reg_wr(base_lo_ofs[rows[i].pin] + 8'h01, rows[i].base[15:8]);
            xbus <= '{addr: rows[i].xa, rd: rows[i].rd, wr: rows[i].wr};
            @(posedge clk);
            @(negedge clk);
            lvl = rows[i].act ? rows[i].pol : ~rows[i].pol;
            chk4("pin_out", {3'h0, lvl} << rows[i].pin, pin_out);
            chk4("pin_oe_n", ~(4'h1 << rows[i].pin), pin_oe_n);
            @(posedge clk);
            xbus <= '{addr: rows[i].xa, rd: 1'h0, wr: 1'h0};
            @(posedge clk);
            @(negedge clk);
            lvl = ~rows[i].pol;
            chk4("idle pin_out", {3'h0, lvl} << rows[i].pin, pin_out);
            @(posedge clk);
        end
        // Register readback, including an unmapped place.
        reg_wr(strobe_dec_pkg::OFS_CFG_LOW, 8'ha5);
        reg_wr(strobe_dec_pkg::OFS_CFG_HIGH, 8'h3c);
        reg_wr(strobe_dec_pkg::OFS_POLARITY, 8'hf0);
        reg_wr(8'h10, 8'hff);
        reg_rd(strobe_dec_pkg::OFS_CFG_LOW, rv);
        chk8("cfg low", 8'ha5, rv);
        reg_rd(strobe_dec_pkg::OFS_CFG_HIGH, rv);
        chk8("cfg high", 8'h3c, rv);
        reg_rd(strobe_dec_pkg::OFS_POLARITY, rv);
        chk8("polarity", 8'hf0, rv);
        reg_rd(8'h10, rv);
        chk8("unmapped", 8'h00, rv);
        // Plain port mode: latch drives, bus traffic must not disturb it.
        reg_wr(strobe_dec_pkg::OFS_CFG_LOW, 8'h00);
        reg_wr(strobe_dec_pkg::OFS_CFG_HIGH, 8'h00);
        reg_wr(strobe_dec_pkg::OFS_PORT_DATA, 8'h05);
        xbus <= '{addr: 16'h1234, rd: 1'h1, wr: 1'h1};
        @(posedge clk);
        @(negedge clk);
        chk4("port pin_out", 4'h0, pin_out);
        chk4("port pin_oe_n", 4'h5, pin_oe_n);
        @(posedge clk);
        xbus <= '0;
        reg_rd(strobe_dec_pkg::OFS_PORT_DATA, rv);
        chk4("port read", 4'h5, rv[3:0]);
        hold_low <= 4'h1;
        reg_rd(strobe_dec_pkg::OFS_PORT_DATA, rv);
        chk4("port read held", 4'h4, rv[3:0]);
        hold_low <= 4'h0;
        // A reset in mid-strobe must drop the strobe at once.
        reg_wr(strobe_dec_pkg::OFS_CFG_LOW, 8'h08);
        xbus <= '{addr: 16'h1234, rd: 1'h0, wr: 1'h1};
        @(posedge clk);
        @(negedge clk);
        chk4("write strobe", 4'h1, pin_out);
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        @(negedge clk);
        chk4("mid reset pin_out", 4'h0, pin_out);
        chk4("mid reset pin_oe_n", 4'hf, pin_oe_n);
        @(posedge clk);
        rst <= 1'h0;
        xbus <= '0;
        @(posedge clk);
        reg_rd(strobe_dec_pkg::OFS_CFG_LOW, rv);
        chk8("cfg after reset", 8'h00, rv);
        give_verdict();
    end
endmodule
